// >>> fps_status_dev.sv
/*
  device end: per-partition status words, status read mode and pin decode.
  assumes the engine reports events as one-cycle pulses on ref_clk and that
  the host keeps address and data steady around each strobe.
*/
`timescale 1ns/1ps
`include "fps_defs.svh"
module fps_status_dev
  import fps_pkg::*;
#(
  parameter logic [7:0] RD_STATUS_OP  = `FPS_OP_RD_STATUS,
  parameter logic [7:0] CLR_STATUS_OP = `FPS_OP_CLR_STATUS
)(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  // flash pins
  fps_link_if.device     link,
  // write engine state
  input  wire logic      eng_busy,
  input  wire fps_part_t eng_part,
  input  wire logic      eng_done,
  input  wire logic      eng_supply_low,
  input  wire logic      eng_prog_fail,
  input  wire logic      eng_erase_fail,
  input  wire logic      eng_seq_err,
  input  wire logic      eng_lock_abort,
  input  wire logic      eng_erase_susp,
  input  wire logic      eng_prog_susp,
  input  wire logic      eng_resume,
  input  wire logic      eng_efp,
  input  wire logic      efp_word_busy,
  // sequence decoder
  input  wire logic      seq_status_req,
  input  wire fps_part_t seq_part,
  output logic           cmd_valid,
  output fps_part_t      cmd_part,
  output fps_dq_t        cmd_data,
  // array read path
  output fps_addr_t      arr_addr,
  input  wire fps_dq_t   arr_word
);
  localparam int NP = `FPS_NPART;
  localparam int PW = 3 + `FPS_ADDR_W + `FPS_DQ_W;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [PW-1:0] pin_s1, pin_s2, pin_s3;
  logic [2:0]    strb_lvl;   // {ce_n, oe_n, we_n} after agreement
  logic [2:0]    strb_q;
  fps_addr_t     a_s;
  fps_dq_t       d_s;

  // three stages; stage one is only read by stage two
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      pin_s1 <= {3'h7, {(PW-3){1'b0}}};
      pin_s2 <= {3'h7, {(PW-3){1'b0}}};
      pin_s3 <= {3'h7, {(PW-3){1'b0}}};
    end
    else
    begin
      pin_s1 <= {link.ce_n, link.oe_n, link.we_n, link.addr, link.dq};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end

  // a strobe change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_strb
      always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
          strb_lvl[gi] <= 1'b1;
        else if (pin_s2[PW-3+gi] == pin_s3[PW-3+gi])
          strb_lvl[gi] <= pin_s3[PW-3+gi];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      strb_q <= 3'h7;
    else
      strb_q <= strb_lvl;

  assign a_s = pin_s3[`FPS_DQ_W +: `FPS_ADDR_W];
  assign d_s = pin_s3[`FPS_DQ_W-1:0];

  // ************************************************************
  // cycle decode
  // ************************************************************
  logic      rd_act, rd_act_q, rd_start, wr_end;
  fps_part_t a_part;
  logic      is_rd_stat, is_clr;

  assign rd_act     = ~strb_lvl[2] & ~strb_lvl[1] & strb_lvl[0];
  assign rd_act_q   = ~strb_q[2] & ~strb_q[1] & strb_q[0];
  assign rd_start   = rd_act & ~rd_act_q;
  assign wr_end     = ~strb_q[2] & ~strb_q[0] & strb_lvl[0];
  assign a_part     = a_s[`FPS_ADDR_W-1 -: `FPS_PART_W];
  assign is_rd_stat = wr_end & (d_s[7:0] == RD_STATUS_OP);
  assign is_clr     = wr_end & (d_s[7:0] == CLR_STATUS_OP);

  // ************************************************************
  // per-partition read mode and status bits
  // ************************************************************
  logic [NP-1:0] mode_stat;
  logic [NP-1:0] esusp, psusp, eerr, perr, vlow, lock;

  // only the addressed partition changes mode; clear-status leaves all alone
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      mode_stat <= '0;
    else
    begin
      if (wr_end && !is_clr)
        mode_stat[a_part] <= is_rd_stat;
      if (seq_status_req)
        mode_stat[seq_part] <= 1'b1;
    end

  // suspend flags belong to the engine: set on acceptance, dropped on resume
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      esusp <= '0;
      psusp <= '0;
    end
    else
    begin
      if (eng_resume)
      begin
        esusp <= '0;
        psusp <= '0;
      end
      if (eng_erase_susp)
        esusp[eng_part] <= 1'b1;
      if (eng_prog_susp)
        psusp[eng_part] <= 1'b1;
    end

  // error flags: clear first so a same-cycle set survives the clear
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      eerr <= '0;
      perr <= '0;
      vlow <= '0;
      lock <= '0;
    end
    else
    begin
      if (is_clr)
      begin
        eerr <= '0;
        perr <= '0;
        vlow <= '0;
        lock <= '0;
      end
      if (eng_erase_fail || eng_seq_err)
        eerr[eng_part] <= 1'b1;
      if (eng_prog_fail || eng_seq_err)
        perr[eng_part] <= 1'b1;
      if (eng_done && eng_supply_low)
        vlow[eng_part] <= 1'b1;
      if (eng_lock_abort)
        lock[eng_part] <= 1'b1;
    end

  // ************************************************************
  // status word assembly
  // ************************************************************
  function automatic fps_stat_t stat_word(input fps_part_t p);
    fps_stat_t w;
    w = '0;
    w[`FPS_B_READY] = ~eng_busy;
    w[`FPS_B_ESUSP] = esusp[p];
    w[`FPS_B_EERR]  = eerr[p];
    w[`FPS_B_PERR]  = perr[p];
    w[`FPS_B_VLOW]  = vlow[p];
    w[`FPS_B_PSUSP] = psusp[p];
    w[`FPS_B_LOCK]  = lock[p];
    // ready forces bit 0 low in both decodes, so 1/1 never shows
    if (eng_efp)
      w[`FPS_B_PWS] = eng_busy & efp_word_busy;
    else
      w[`FPS_B_PWS] = eng_busy & (eng_part != p);
    return w;
  endfunction

  // ************************************************************
  // read data and command hand-off
  // ************************************************************
  fps_dq_t rd_data;
  logic    rd_oe;

  // snapshot taken once per read; polling needs a fresh strobe fall
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      rd_data <= '0;
    else if (rd_start)
    begin
      if (mode_stat[a_part])
        rd_data <= {8'h00, stat_word(a_part)};
      else
        rd_data <= arr_word;
    end

  // bursts are not supported: each read cycle gives one word
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      rd_oe <= 1'b0;
    else
      rd_oe <= rd_act;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      arr_addr <= '0;
    else
      arr_addr <= a_s;

  // commands other than the two status opcodes go on to the decoder
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cmd_valid <= 1'b0;
      cmd_part  <= '0;
      cmd_data  <= '0;
    end
    else
    begin
      cmd_valid <= wr_end & ~is_rd_stat & ~is_clr;
      if (wr_end)
      begin
        cmd_part <= a_part;
        cmd_data <= d_s;
      end
    end

  assign link.dev_dq_out = rd_data;
  assign link.dev_dq_oe  = rd_oe;
endmodule // fps_status_dev

// >>> fps_defs.svh
/*
  constants for the partition status block: sizes, bit positions, opcodes,
  register offsets and pin timing. assumes a 10 MHz ref_clk.
*/
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH
// Operation
// - read-status command sets partition status mode
// - program/erase/lock sequence auto enters status mode
// - single reads return status until new command
// - only single reads in status mode
// - fresh status latched on first strobe fall
// - other partitions keep their read modes
// - status on low byte, upper byte zero
// - per-partition bits 6..0, bit 7 device-wide; in fast factory mode bit 0 is device-wide
// - bit 7 ready flag, others invalid if busy
// - erase suspend sets bit 6 until resume
// - bit 5 erase fail; 7,5,4 sequence error
// - bit 4 set on program failure
// - bit 3 low supply sampled at completion
// - program suspend sets bit 2 until resume
// - locked block attempt sets bit 1, aborts
// - normal decode of bit 7 and bit 0
// - fast factory decode of bit 7 and 0
// - clear-status keeps every partition read mode
// - engine bits live; error bits sticky until clear
// - host clears status after error before continuing
// - reset clears the whole status word; bits 7 and 0 still follow eng_busy
// ************************************************************
// sizes
// ************************************************************
`define FPS_NPART       4
`define FPS_PART_W      2
`define FPS_ADDR_W      8
`define FPS_DQ_W        16
// ************************************************************
// status word bit positions
// ************************************************************
`define FPS_B_READY     7
`define FPS_B_ESUSP     6
`define FPS_B_EERR      5
`define FPS_B_PERR      4
`define FPS_B_VLOW      3
`define FPS_B_PSUSP     2
`define FPS_B_LOCK      1
`define FPS_B_PWS       0
// ************************************************************
// command opcodes (low byte of the write data)
// ************************************************************
`define FPS_OP_RD_STATUS  8'ha1
`define FPS_OP_CLR_STATUS 8'ha2
// ************************************************************
// host register offsets and reset values
// ************************************************************
`define FPS_OFS_CMD     8'h00
`define FPS_OFS_STAT    8'h04
`define FPS_CMD_RST     32'h0000_0000
// ************************************************************
// pin timing
// ************************************************************
`define FPS_CLK_NS      100
`define FPS_T_SETUP_NS  300
`define FPS_T_STROBE_NS 1000
`define FPS_T_HOLD_NS   300
`define FPS_SETUP_CYC   ((`FPS_T_SETUP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_STROBE_CYC  ((`FPS_T_STROBE_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_HOLD_CYC    ((`FPS_T_HOLD_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`endif

// >>> fps_pkg.sv
/*
  types shared by both ends of the partition status link.
  assumes fps_defs.svh is on the include path.
*/
`include "fps_defs.svh"
package fps_pkg;
  typedef logic [`FPS_PART_W-1:0] fps_part_t;
  typedef logic [`FPS_ADDR_W-1:0] fps_addr_t;
  typedef logic [`FPS_DQ_W-1:0]   fps_dq_t;
  typedef logic [7:0]             fps_stat_t;
  typedef enum logic [1:0] {FPS_H_IDLE, FPS_H_SETUP, FPS_H_STROBE, FPS_H_HOLD} fps_hstate_t;
endpackage

// >>> fps_link_if.sv
/*
  flash pin carrier between host controller and device.
  the shared data bus is resolved here from the two enables.
*/
`timescale 1ns/1ps
interface fps_link_if;
  import fps_pkg::*;
  logic      ce_n;
  logic      oe_n;
  logic      we_n;
  fps_addr_t addr;
  fps_dq_t   host_dq_out;
  logic      host_dq_oe;
  fps_dq_t   dev_dq_out;
  logic      dev_dq_oe;
  fps_dq_t   dq;
  // device wins a clash; an undriven bus reads zero
  assign dq = dev_dq_oe ? dev_dq_out : (host_dq_oe ? host_dq_out : '0);
  modport host   (output ce_n, oe_n, we_n, addr, host_dq_out, host_dq_oe, input dq);
  modport device (input ce_n, oe_n, we_n, addr, dq, output dev_dq_out, dev_dq_oe);
endinterface

// >>> fps_status_host.sv
/*
  host end: ahb-lite register slave that runs single flash bus cycles.
  assumes a single ahb master and a device on the far side of fps_link_if.
*/
`timescale 1ns/1ps
`include "fps_defs.svh"
module fps_status_host
  import fps_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // flash pins
  fps_link_if.host         link
);
  localparam logic [3:0] SETUP_N  = 4'(`FPS_SETUP_CYC);
  localparam logic [3:0] STROBE_N = 4'(`FPS_STROBE_CYC);
  localparam logic [3:0] HOLD_N   = 4'(`FPS_HOLD_CYC);

  // ************************************************************
  // register slave
  // ************************************************************
  logic        wr_pend;
  logic [7:0]  wr_ofs;
  logic [31:0] cmd_reg;
  fps_dq_t     rdata_reg;
  logic        busy;
  logic        go;
  fps_hstate_t st;

  assign hreadyout = 1'b1;  // zero wait states; hsize is always a word
  assign hresp     = 1'b0;
  assign go        = wr_pend && (wr_ofs == `FPS_OFS_CMD) && !busy;

  // read data is chosen in the address phase so it stands from a flop
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      wr_pend <= 1'b0;
      wr_ofs  <= '0;
      hrdata  <= '0;
    end
    else if (hready)
    begin
      wr_pend <= hsel & htrans[1] & hwrite;
      wr_ofs  <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite)
      begin
        if (haddr[7:0] == `FPS_OFS_CMD)
          hrdata <= cmd_reg;
        else if (haddr[7:0] == `FPS_OFS_STAT)
          hrdata <= {15'h0000, busy, rdata_reg};
        else
          hrdata <= '0;
      end
    end

  // a write while a cycle runs is dropped
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      cmd_reg <= `FPS_CMD_RST;
    else if (go)
      cmd_reg <= hwdata;

  // ************************************************************
  // read data synchroniser
  // ************************************************************
  fps_dq_t dq_s1, dq_s2, dq_s3;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end
    else
    begin
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end

  // ************************************************************
  // pin sequencer
  // ************************************************************
  logic [3:0] cnt;
  logic       is_rd;
  assign busy = (st != FPS_H_IDLE);

  // only single cycles are issued, never bursts; status
  // reads after an error are up to software, which clears first
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      st               <= FPS_H_IDLE;
      cnt              <= '0;
      is_rd            <= 1'b0;
      rdata_reg        <= '0;
      link.ce_n        <= 1'b1;
      link.oe_n        <= 1'b1;
      link.we_n        <= 1'b1;
      link.addr        <= '0;
      link.host_dq_out <= '0;
      link.host_dq_oe  <= 1'b0;
    end
    else
    begin
      case (st)
        FPS_H_IDLE:
          if (go)
          begin
            st               <= FPS_H_SETUP;
            cnt              <= SETUP_N;
            is_rd            <= hwdata[24];
            link.ce_n        <= 1'b0;
            link.addr        <= hwdata[23:16];
            link.host_dq_out <= hwdata[15:0];
            link.host_dq_oe  <= ~hwdata[24];
          end
        FPS_H_SETUP:
          if (cnt == 4'h1)
          begin
            st        <= FPS_H_STROBE;
            cnt       <= STROBE_N;
            link.oe_n <= ~is_rd;
            link.we_n <= is_rd;
          end
          else
            cnt <= cnt - 4'h1;
        FPS_H_STROBE:
          if (cnt == 4'h1)
          begin
            st        <= FPS_H_HOLD;
            cnt       <= HOLD_N;
            link.oe_n <= 1'b1;
            link.we_n <= 1'b1;
            if (is_rd)
              rdata_reg <= dq_s3;
          end
          else
            cnt <= cnt - 4'h1;
        FPS_H_HOLD:
          if (cnt == 4'h1)
          begin
            st              <= FPS_H_IDLE;
            link.ce_n       <= 1'b1;
            link.host_dq_oe <= 1'b0;
          end
          else
            cnt <= cnt - 4'h1;
        default:
          st <= FPS_H_IDLE;
      endcase
    end
endmodule // fps_status_host

// >>> fps_link_sva.sv
/*
  checker for the flash pin link between host and device ends.
  assumes it is instantiated in tb beside the interface, on ref_clk.
*/
`timescale 1ns/1ps
module fps_link_sva
  import fps_pkg::*;
(
  // clock and reset
  input wire logic      ref_clk,
  input wire logic      rst_n,
  // host pins
  input wire logic      ce_n,
  input wire logic      oe_n,
  input wire logic      we_n,
  input wire fps_addr_t addr,
  input wire fps_dq_t   host_dq_out,
  input wire logic      host_dq_oe,
  // device pins and bus
  input wire fps_dq_t   dev_dq_out,
  input wire logic      dev_dq_oe,
  input wire fps_dq_t   dq
);
  // ************************************************************
  // pin protocol
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a single strobe of ten cycles, never a burst of strobes
  sequence s_oe_ten;
    (!oe_n)[*8] ##1 !oe_n ##1 oe_n;
  endsequence
  sequence s_ce_frame;
    (!ce_n)[*8] ##7 !ce_n ##1 ce_n;
  endsequence
  property p_oe_single;
    $fell(oe_n) |=> s_oe_ten;
  endproperty
  property p_ce_frame;
    $fell(ce_n) |=> s_ce_frame;
  endproperty
  property p_strobe_start;
    $fell(ce_n) |-> ##3 ($fell(oe_n) || $fell(we_n));
  endproperty
  property p_one_strobe;
    !(!oe_n && !we_n);
  endproperty
  property p_idle_gap;
    $rose(ce_n) |=> ce_n;
  endproperty
  property p_addr_held;
    (!ce_n && $past(ce_n) == 1'b0) |-> $stable(addr);
  endproperty
  // the command word must not move under the write strobe
  property p_wdata_held;
    (!we_n && $past(we_n) == 1'b0) |-> host_dq_oe && $stable(host_dq_out);
  endproperty
  property p_no_clash;
    dev_dq_oe |-> !host_dq_oe && we_n;
  endproperty
  property p_dev_after_fall;
    $rose(dev_dq_oe) |-> !oe_n && !ce_n;
  endproperty
  a_oe_single: assert property (p_oe_single) else $error("read strobe length wrong");
  a_ce_frame: assert property (p_ce_frame) else $error("chip enable frame length wrong");
  a_strobe_start: assert property (p_strobe_start) else $error("strobe not three cycles after enable");
  a_one_strobe: assert property (p_one_strobe) else $error("read and write strobe together");
  a_idle_gap: assert property (p_idle_gap) else $error("no idle cycle between bus cycles");
  a_addr_held: assert property (p_addr_held) else $error("address moved inside a bus cycle");
  a_wdata_held: assert property (p_wdata_held) else $error("command data moved under write strobe");
  a_no_clash: assert property (p_no_clash) else $error("device drives during a write");
  a_dev_after_fall: assert property (p_dev_after_fall) else $error("device drove without a read strobe");
  c_status_read: cover property ($rose(dev_dq_oe) ##1 (dq[15:8] == 8'h00));
endmodule // fps_link_sva

// >>> tb.sv
/*
  self-checking bench: both ends joined by fps_link_if, host driven over ahb.
  assumes fps_defs.svh on the include path and a 10 MHz ref_clk.
*/
`timescale 1ns/1ps
`include "fps_defs.svh"
module tb import fps_pkg::*;;
  localparam fps_dq_t ARR = 16'h5a3c;
  logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, cmd_valid;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        eng_busy, eng_supply_low, eng_efp, efp_word_busy;
  logic [8:0]  ev;
  fps_part_t   eng_part, seq_part, cmd_part;
  fps_dq_t     cmd_data, last_cmd;
  fps_addr_t   arr_addr;
  int          n_errors, checked, n_cmd;
  fps_link_if link();
  fps_status_host i_fps_status_host(.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  // event pulses share one vector so one task raises any of them
  fps_status_dev i_fps_status_dev(.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .eng_busy(eng_busy),
    .eng_part(eng_part), .eng_done(ev[0]), .eng_supply_low(eng_supply_low), .eng_prog_fail(ev[1]),
    .eng_erase_fail(ev[2]), .eng_seq_err(ev[3]), .eng_lock_abort(ev[4]), .eng_erase_susp(ev[5]),
    .eng_prog_susp(ev[6]), .eng_resume(ev[7]), .eng_efp(eng_efp), .efp_word_busy(efp_word_busy),
    .seq_status_req(ev[8]), .seq_part(seq_part), .cmd_valid(cmd_valid), .cmd_part(cmd_part),
    .cmd_data(cmd_data), .arr_addr(arr_addr), .arr_word(ARR));
  fps_link_sva i_fps_link_sva(.ref_clk(ref_clk), .rst_n(rst_n), .ce_n(link.ce_n), .oe_n(link.oe_n),
    .we_n(link.we_n), .addr(link.addr), .host_dq_out(link.host_dq_out), .host_dq_oe(link.host_dq_oe),
    .dev_dq_out(link.dev_dq_out), .dev_dq_oe(link.dev_dq_oe), .dq(link.dq));
  // ************************************************************
  // clock, monitor and shared tasks
  // ************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // forwarded commands are counted here, the pulse lasts one cycle
  always @(posedge ref_clk)
    if (cmd_valid === 1'b1)
    begin
      n_cmd++;
      last_cmd = cmd_data;
    end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  // one flash bus cycle, polled until the host end goes idle
  task automatic flash(input logic rd, input fps_addr_t a, input logic [15:0] d);
    int n;
    n = 0;
    ahb(1'b1, 32'h0000_0000, {7'h00, rd, a, d});
    do
    begin
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
      n++;
    end
    while (rdat[16] !== 1'b0 && n < 200);
    // a poll limit that runs out, or an error response, counts as a mismatch
    chk({14'h0000, hresp, rdat[16]}, 16'h0000, "host busy or error response");
  endtask
  task automatic cmd(input fps_part_t p, input logic [7:0] op);
    flash(1'b0, {p, 6'h2a}, {8'h00, op});
  endtask
  task automatic rd_chk(input fps_part_t p, input fps_dq_t e, input string what);
    flash(1'b1, {p, 6'h15}, 16'h0000);
    chk(rdat[15:0], e, what);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev <= '0;
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_modes;
    rd_chk(2'd1, ARR, "array read after reset");
    cmd(2'd1, `FPS_OP_RD_STATUS);
    rd_chk(2'd1, 16'h0080, "idle status");
    rd_chk(2'd0, ARR, "other partition mode");
    chk({8'h00, arr_addr}, 16'h0015, "array address");
    rd_chk(2'd1, 16'h0080, "repeated status read");
  endtask
  task automatic t_decode;
    eng_busy <= 1'b1;
    eng_part <= 2'd1;
    seq_part <= 2'd2;
    pulse(8);
    rd_chk(2'd1, 16'h0000, "own partition busy");
    rd_chk(2'd2, 16'h0001, "other partition busy");
    eng_efp       <= 1'b1;
    efp_word_busy <= 1'b1;
    rd_chk(2'd1, 16'h0001, "fast program working");
    efp_word_busy <= 1'b0;
    rd_chk(2'd1, 16'h0000, "fast program word done");
    // the exit decode is read while the fast mode is still selected
    eng_busy <= 1'b0;
    rd_chk(2'd1, 16'h0080, "fast program exit");
    eng_efp <= 1'b0;
  endtask
  task automatic t_errors;
    pulse(2);
    rd_chk(2'd1, 16'h00a0, "erase error");
    eng_supply_low <= 1'b1;
    pulse(1);
    rd_chk(2'd1, 16'h00b0, "program error, supply not sampled");
    pulse(0);
    eng_supply_low <= 1'b0;
    rd_chk(2'd1, 16'h00b8, "supply low at completion");
    pulse(4);
    rd_chk(2'd1, 16'h00ba, "locked block abort");
    rd_chk(2'd2, 16'h0080, "errors of one partition only");
    cmd(2'd1, `FPS_OP_CLR_STATUS);
    rd_chk(2'd1, 16'h0080, "errors cleared");
    rd_chk(2'd0, ARR, "clear keeps array mode");
    rd_chk(2'd2, 16'h0080, "clear keeps status mode");
    pulse(3);
    rd_chk(2'd1, 16'h00b0, "sequence error");
    cmd(2'd1, `FPS_OP_CLR_STATUS);
  endtask
  task automatic t_suspend;
    pulse(5);
    rd_chk(2'd1, 16'h00c0, "erase suspend");
    cmd(2'd1, `FPS_OP_CLR_STATUS);
    rd_chk(2'd1, 16'h00c0, "suspend survives clear");
    pulse(6);
    rd_chk(2'd1, 16'h00c4, "program suspend");
    pulse(7);
    rd_chk(2'd1, 16'h0080, "resume clears suspend");
  endtask
  task automatic t_exit;
    cmd(2'd1, 8'h55);
    // the device sees the strobe end only after the host has gone idle
    repeat (3) @(posedge ref_clk);
    chk(16'(n_cmd), 16'h0001, "forwarded command count");
    chk(last_cmd, 16'h0055, "forwarded command data");
    chk({14'h0000, cmd_part}, 16'h0001, "forwarded command partition");
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rdat[31:16], 16'h006a, "command register address field");
    rd_chk(2'd1, ARR, "new command leaves status mode");
  endtask
  // reset in mid-run with an error pending
  task automatic t_reset_mid;
    pulse(2);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk(2'd2, ARR, "reset restores array mode");
    cmd(2'd1, `FPS_OP_RD_STATUS);
    rd_chk(2'd1, 16'h0080, "reset clears status");
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {eng_busy, eng_supply_low, eng_efp, efp_word_busy} = '0;
    ev       = '0;
    eng_part = '0;
    seq_part = '0;
    n_errors = 0;
    checked  = 0;
    n_cmd    = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_modes;
    t_decode;
    t_errors;
    t_suspend;
    t_exit;
    t_reset_mid;
    tally_and_finish;
  end
  // a run needs about 700 cycles; this limit only cuts a hang
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end
endmodule // tb
